// ===== inc/lde_defines.svh
// Register map, field positions and reset values of the lane deskew and code error monitor.
// Assumes an 8-bit register port addressed with the printed offsets.
`ifndef LDE_DEFINES_SVH
`define LDE_DEFINES_SVH
`define LDE_ADDR_W 12
`define LDE_OFF_READBACK 12'h46b
`define LDE_OFF_ALIGN_EN 12'h46c
`define LDE_OFF_DISP 12'h46d
`define LDE_OFF_TMISS 12'h46e
`define LDE_OFF_CCHAR 12'h46f
`define LDE_OFF_THRESH 12'h07c
`define LDE_OFF_IRQ_STAT 12'h480
`define LDE_OFF_IRQ_MASK 12'h481
`define LDE_OFF_MODE 12'h482
`define LDE_ALIGN_EN_RST 8'h0f
`define LDE_THRESH_RST 8'hff
`define LDE_BIT_IRQ_CLR 7
`define LDE_BIT_CNT_OFF 6
`define LDE_BIT_CNT_CLR 5
`define LDE_LANE_MSB 2
`define LDE_RB_LANE_MSB 6
`define LDE_RB_LANE_LSB 4
`define LDE_RB_CNT_MSB 1
`define LDE_DUAL_MASK 8'h0f
`endif

// ===== inc/lde_pkg.sv
// Types shared by the lane deskew and code error monitor.
// Assumes lde_defines.svh is on the include path.
package lde_pkg;
    typedef enum logic [1:0] {
        LDE_CAT_DISP = 2'b00,
        LDE_CAT_TMISS = 2'b01,
        LDE_CAT_CCHAR = 2'b10
    } lde_cat_t;
    typedef logic [7:0] lde_byte_t;
endpackage

// ===== logic/lde_err_counter.sv
// One lane's error counter for one error category, with threshold flag.
// Assumes errors arrive as single-cycle pulses on ref_clk.
`timescale 1ns/100ps
module lde_err_counter #(
    parameter int CW = 8
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic errPulse,
    input wire logic countOff,
    input wire logic countClear,
    input wire logic [CW-1:0] threshold,
    output logic [CW-1:0] count,
    output logic hit
);
    import lde_pkg::*;
    initial begin
        if (CW < 1) $error("CW must be at least 1");
    end
    logic [CW-1:0] count_r;
    logic off_r;
    wire logic sat = &count_r;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            count_r <= '0;
            off_r <= 1'b0;
        end else begin
            if (countOff) off_r <= 1'b1;
            else if (countClear) off_r <= 1'b0;
            if (countClear) count_r <= '0; // R05 R10
            else if (errPulse && !off_r && !sat) count_r <= CW'(count_r + 1'b1); // R04 R09
        end
    end
    assign count = count_r;
    assign hit = (count_r >= threshold); // R06
endmodule

// ===== logic/lde_lane_errs.sv
// Three category counters of one lane plus their sticky IRQ flags.
// Assumes command pulses last one cycle.
`timescale 1ns/100ps
module lde_lane_errs (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [2:0] errPulse,
    input wire logic [2:0] countOff,
    input wire logic [2:0] countClear,
    input wire logic [2:0] irqClear,
    input wire logic [7:0] threshold,
    output logic [23:0] counts,
    output logic [2:0] hit,
    output logic [2:0] irqFlag
);
    import lde_pkg::*;
    logic [2:0] irq_r;
    logic [2:0] hitPrev_r;
    for (genvar c = 0; c < 3; c++) begin : g_cat
        lde_err_counter #(.CW(8)) u_cnt (
            .ref_clk(ref_clk),
            .reset(reset),
            .errPulse(errPulse[c]),
            .countOff(countOff[c]),
            .countClear(countClear[c]),
            .threshold(threshold),
            .count(counts[c*8 +: 8]),
            .hit(hit[c])
        );
    end
    wire logic [2:0] rise = hit & ~hitPrev_r;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_r <= '0;
            hitPrev_r <= '0;
        end else begin
            hitPrev_r <= hit;
            irq_r <= rise | (irq_r & ~irqClear); // R03 R08
        end
    end
    assign irqFlag = irq_r;
endmodule

// ===== logic/lde_monitor.sv
// Behaviour
// R01 - Eight deskew enable bits, one per lane, reset to lanes 0 to 3 enabled.
// R02 - In dual link mode only the low four lane bits of deskew and status are used.
// R03 - Writing 1 to bit 7 of the disparity control register clears that lane's disparity IRQ.
// R04 - Writing 1 to bit 6 of the disparity control register disables that lane's counter.
// R05 - Writing 1 to bit 5 of the disparity control register zeroes that lane's counter.
// R06 - Reading the disparity register gives one threshold-reached bit per lane.
// R07 - Counts are readable through the indirect readback register.
// R08 - Bit 7 of the table-miss or control-char register clears that category's lane IRQ.
// R09 - Writing 1 to bit 6 of the table-miss register disables that lane's counter.
// R10 - Writing 1 to bit 5 of the table-miss register zeroes that lane's counter.
// R11 - Reading the table-miss register gives one status bit per lane.
// R12 - Bits 2 to 0 written with the command bits pick the lane they act on.
// R13 - Software writes lane and counter select before reading the readback location.
// R14 - Counter select 0 is disparity, 1 table miss, 2 control character.
// R15 - Command bits are single-cycle pulses; writing 0 does nothing.
//
// Top of the lane deskew and code error monitor, with its register port.
// Assumes error pulses come from the lane decoders on ref_clk.
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`include "lde_defines.svh"
module lde_monitor #(
    parameter int LANES = 8
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [`LDE_ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output lde_pkg::lde_byte_t regRdData,
    input wire logic [LANES-1:0] dispErr,
    input wire logic [LANES-1:0] tableMissErr,
    input wire logic [LANES-1:0] ctrlCharErr,
    output logic [LANES-1:0] laneAlignEnable,
    output logic irq
);
    import lde_pkg::*;
    initial begin
        if (LANES != 8) $error("LANES must be 8");
    end

    logic [7:0] alignEn_r;
    logic [7:0] thresh_r;
    logic [2:0] rbLane_r;
    logic [1:0] rbCnt_r;
    logic [2:0] irqStat_r;
    logic [2:0] irqMask_r;
    logic dualLink_r;
    lde_byte_t rdData_r;
    lde_byte_t rdData_nxt;
    logic [LANES-1:0] alignOut_r;
    logic irq_r;

    wire logic wrAlign = regWrite && regAddr == `LDE_OFF_ALIGN_EN;
    wire logic wrDisp = regWrite && regAddr == `LDE_OFF_DISP;
    wire logic wrTmiss = regWrite && regAddr == `LDE_OFF_TMISS;
    wire logic wrCchar = regWrite && regAddr == `LDE_OFF_CCHAR;
    wire logic wrRb = regWrite && regAddr == `LDE_OFF_READBACK;
    wire logic wrThresh = regWrite && regAddr == `LDE_OFF_THRESH;
    wire logic wrStat = regWrite && regAddr == `LDE_OFF_IRQ_STAT;
    wire logic wrMask = regWrite && regAddr == `LDE_OFF_IRQ_MASK;
    wire logic wrMode = regWrite && regAddr == `LDE_OFF_MODE;

    // Per category command strobes, category index as in lde_cat_t
    wire logic [2:0] catWr = {wrCchar, wrTmiss, wrDisp};
    wire logic [2:0] laneAddr = regWrData[`LDE_LANE_MSB:0]; // R12
    wire logic cmdIrqClr = regWrData[`LDE_BIT_IRQ_CLR];
    wire logic cmdOff = regWrData[`LDE_BIT_CNT_OFF];
    wire logic cmdClr = regWrData[`LDE_BIT_CNT_CLR];

    // Dual link keeps lanes 4 to 7 idle in this instance
    wire logic [7:0] laneUse = dualLink_r ? `LDE_DUAL_MASK : 8'hff; // R02

    logic [3*LANES-1:0] hitFlat;
    logic [3*LANES-1:0] irqFlat;
    logic [24*LANES-1:0] cntFlat;
    logic [LANES-1:0] dispHit;
    logic [LANES-1:0] tmissHit;
    logic [LANES-1:0] cchrHit;
    logic [LANES-1:0] dispIrq;
    logic [LANES-1:0] tmissIrq;
    logic [LANES-1:0] cchrIrq;

    for (genvar l = 0; l < LANES; l++) begin : g_lane
        wire logic sel = laneAddr == 3'(l);
        // Strobes are combinational from a one-cycle write, so they cannot linger
        wire logic [2:0] offP = catWr & {3{sel && cmdOff}}; // R04 R09 R15
        wire logic [2:0] clrP = catWr & {3{sel && cmdClr}}; // R05 R10 R15
        wire logic [2:0] irqP = catWr & {3{sel && cmdIrqClr}}; // R03 R08 R15
        wire logic [2:0] errs = {ctrlCharErr[l], tableMissErr[l], dispErr[l]} &
            {3{laneUse[l]}};
        lde_lane_errs u_lane (
            .ref_clk(ref_clk),
            .reset(reset),
            .errPulse(errs),
            .countOff(offP),
            .countClear(clrP),
            .irqClear(irqP),
            .threshold(thresh_r),
            .counts(cntFlat[l*24 +: 24]),
            .hit(hitFlat[l*3 +: 3]),
            .irqFlag(irqFlat[l*3 +: 3])
        );
        assign dispHit[l] = hitFlat[l*3] & laneUse[l]; // R06
        assign tmissHit[l] = hitFlat[l*3+1] & laneUse[l]; // R11
        assign cchrHit[l] = hitFlat[l*3+2] & laneUse[l];
        assign dispIrq[l] = irqFlat[l*3];
        assign tmissIrq[l] = irqFlat[l*3+1];
        assign cchrIrq[l] = irqFlat[l*3+2];
    end

    // Indirect readback; select 3 is not a counter and reads zero
    wire logic [23:0] laneCnts = cntFlat[rbLane_r*24 +: 24]; // R07 R13
    wire logic [7:0] rbValue = (rbCnt_r == LDE_CAT_DISP) ? laneCnts[7:0] :
        (rbCnt_r == LDE_CAT_TMISS) ? laneCnts[15:8] :
        (rbCnt_r == LDE_CAT_CCHAR) ? laneCnts[23:16] : 8'h00; // R14

    wire logic [2:0] catEvt = {|cchrIrq, |tmissIrq, |dispIrq};

    always_comb begin
        rdData_nxt = 8'h00;
        if (regRead) begin
            unique case (regAddr)
                `LDE_OFF_READBACK: rdData_nxt = rbValue;
                `LDE_OFF_ALIGN_EN: rdData_nxt = alignEn_r;
                `LDE_OFF_DISP: rdData_nxt = dispHit;
                `LDE_OFF_TMISS: rdData_nxt = tmissHit;
                `LDE_OFF_CCHAR: rdData_nxt = 8'h00;
                `LDE_OFF_THRESH: rdData_nxt = thresh_r;
                `LDE_OFF_IRQ_STAT: rdData_nxt = {5'h00, irqStat_r};
                `LDE_OFF_IRQ_MASK: rdData_nxt = {5'h00, irqMask_r};
                `LDE_OFF_MODE: rdData_nxt = {7'h00, dualLink_r};
                default: rdData_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            alignEn_r <= `LDE_ALIGN_EN_RST; // R01
            thresh_r <= `LDE_THRESH_RST;
            rbLane_r <= '0;
            rbCnt_r <= '0;
            dualLink_r <= 1'b0;
            irqMask_r <= '0;
        end else begin
            if (wrAlign) alignEn_r <= regWrData; // R01
            if (wrThresh) thresh_r <= regWrData;
            if (wrRb) begin
                rbLane_r <= regWrData[`LDE_RB_LANE_MSB:`LDE_RB_LANE_LSB]; // R13
                rbCnt_r <= regWrData[`LDE_RB_CNT_MSB:0];
            end
            if (wrMode) dualLink_r <= regWrData[0];
            if (wrMask) irqMask_r <= regWrData[2:0];
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (reset) irqStat_r <= '0;
        else irqStat_r <= catEvt | (irqStat_r & ~({3{wrStat}} & regWrData[2:0]));
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdData_r <= 8'h00;
            alignOut_r <= '0;
            irq_r <= 1'b0;
        end else begin
            rdData_r <= rdData_nxt;
            alignOut_r <= alignEn_r & laneUse; // R02
            irq_r <= |(irqStat_r & irqMask_r);
        end
    end

    assign regRdData = rdData_r;
    assign laneAlignEnable = alignOut_r;
    assign irq = irq_r;
endmodule

// ===== tb/lde_err_source.sv
// Far-side model: the lane decoders fed by the link transmitter, as error pulses.
// Assumes the testbench calls burst from one process at a time.
`timescale 1ns/100ps
module lde_err_source (
    input wire logic ref_clk,
    output logic [7:0] dispErr,
    output logic [7:0] tableMissErr,
    output logic [7:0] ctrlCharErr
);
    initial begin
        dispErr = '0;
        tableMissErr = '0;
        ctrlCharErr = '0;
    end
    // A gap cycle between pulses, so each pulse counts as one error
    task automatic burst(input int cat, input int lane, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            case (cat)
                0: dispErr[lane] <= 1'b1;
                1: tableMissErr[lane] <= 1'b1;
                default: ctrlCharErr[lane] <= 1'b1;
            endcase
            @(posedge ref_clk);
            dispErr <= '0;
            tableMissErr <= '0;
            ctrlCharErr <= '0;
        end
    endtask
endmodule

// ===== tb/lde_monitor_checker.sv
// Port assertions for the lane deskew and code error monitor.
// Assumes a single clock domain; bound to every monitor instance.
`timescale 1ns/100ps
`include "lde_defines.svh"
module lde_monitor_checker #(
    parameter int LANES = 8
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [`LDE_ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input lde_pkg::lde_byte_t regRdData,
    input wire logic [LANES-1:0] dispErr,
    input wire logic [LANES-1:0] tableMissErr,
    input wire logic [LANES-1:0] ctrlCharErr,
    input wire logic [LANES-1:0] laneAlignEnable,
    input wire logic irq
);
    import lde_pkg::*;
    logic dualMode_r;
    logic [2:0] irqMask_r;
    logic quiet_r;
    wire wrAlign = regWrite && regAddr == `LDE_OFF_ALIGN_EN;
    wire wrMode = regWrite && regAddr == `LDE_OFF_MODE;
    wire wrMask = regWrite && regAddr == `LDE_OFF_IRQ_MASK;
    wire anyEvt = (regWrite && regAddr == `LDE_OFF_THRESH) || |{dispErr, tableMissErr, ctrlCharErr};
    wire [LANES-1:0] laneMask = dualMode_r ? LANES'(8'h0f) : '1;
    // Quiet means nothing could yet have raised a count or a status bit
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dualMode_r <= 1'b0;
            irqMask_r <= 3'h0;
            quiet_r <= 1'b1;
        end else begin
            if (wrMode) dualMode_r <= regWrData[0];
            if (wrMask) irqMask_r <= regWrData[2:0];
            if (anyEvt) quiet_r <= 1'b0;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence alignWrOnce;
        wrAlign ##1 !wrAlign;
    endsequence
    alignWr_a: assert property (alignWrOnce |=> laneAlignEnable ==
        (LANES'($past(regWrData, 2)) & $past(laneMask))) else $error("deskew enable wrong");
    alignHold_a: assert property ($changed(laneAlignEnable) && !$past(reset, 2)
        |-> $past(wrAlign || wrMode, 2)) else $error("deskew enable moved alone");
    rdIdle_a: assert property (!regRead |=> regRdData == 8'h00) else $error("stray read data");
    ccharRd_a: assert property (regRead && regAddr == `LDE_OFF_CCHAR |=> regRdData == 8'h00)
        else $error("write-only register read back");
    irqOff_a: assert property ($past(irqMask_r) == 3'h0 |-> !irq) else $error("masked irq high");
    dispQuiet_a: assert property (quiet_r && regRead && regAddr == `LDE_OFF_DISP
        |=> regRdData == 8'h00) else $error("disparity status without errors");
    tmissQuiet_a: assert property (quiet_r && regRead && regAddr == `LDE_OFF_TMISS
        |=> regRdData == 8'h00) else $error("table miss status without errors");
    cntQuiet_a: assert property (quiet_r && regRead && regAddr == `LDE_OFF_READBACK
        |=> regRdData == 8'h00) else $error("count without errors");
endmodule
bind lde_monitor lde_monitor_checker #(.LANES(LANES)) chk_i (.ref_clk(ref_clk), .reset(reset),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .dispErr(dispErr), .tableMissErr(tableMissErr),
    .ctrlCharErr(ctrlCharErr), .laneAlignEnable(laneAlignEnable), .irq(irq));

// ===== tb/tb_lde_monitor.sv
// Self-checking bench for the monitor, with the error source as far side.
// Assumes the threshold register at its printed offset and the mask reset to 0.
`timescale 1ns/100ps
`include "lde_defines.svh"
module tb_lde_monitor;
    import lde_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [`LDE_ADDR_W-1:0] regAddr = '0;
    lde_byte_t regWrData = '0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    lde_byte_t regRdData;
    logic [7:0] dispErr, tableMissErr, ctrlCharErr, laneAlignEnable;
    logic irq;
    int miscompares = 0;
    int checksDone = 0;
    lde_monitor #(.LANES(8)) uut (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .dispErr(dispErr), .tableMissErr(tableMissErr), .ctrlCharErr(ctrlCharErr),
        .laneAlignEnable(laneAlignEnable), .irq(irq));
    lde_err_source src (.ref_clk(ref_clk), .dispErr(dispErr), .tableMissErr(tableMissErr),
        .ctrlCharErr(ctrlCharErr));
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic chk(input lde_byte_t got, input lde_byte_t exp);
        checksDone++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [11:0] a, input lde_byte_t d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rc(input logic [11:0] a, input lde_byte_t exp);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 chk(regRdData, exp);
    endtask
    task automatic rb(input logic [2:0] lane, input logic [1:0] sel, input lde_byte_t exp);
        wr(12'h46b, {1'b0, lane, 2'b00, sel});
        rc(12'h46b, exp);
    endtask
    task automatic t_reset;
        rc(12'h46c, 8'h0f);
        chk(laneAlignEnable, 8'h0f);
        rc(12'h46d, 8'h00);
        rc(12'h46f, 8'h00);
    endtask
    task automatic t_align;
        wr(12'h46c, 8'ha5);
        rc(12'h46c, 8'ha5);
        chk(laneAlignEnable, 8'ha5);
        wr(12'h482, 8'h01);
        idle(2);
        chk(laneAlignEnable, 8'h05);
        wr(12'h482, 8'h00);
    endtask
    task automatic t_count;
        wr(12'h07c, 8'h03);
        src.burst(0, 2, 3);
        idle(3);
        rc(12'h46d, 8'h04);
        rb(3'd2, 2'd0, 8'h03);
        src.burst(1, 5, 3);
        src.burst(2, 1, 1);
        idle(3);
        rc(12'h46e, 8'h20);
        rb(3'd5, 2'd1, 8'h03);
        rb(3'd1, 2'd2, 8'h01);
    endtask
    task automatic t_cmd;
        wr(12'h46d, 8'h42);
        src.burst(0, 2, 2);
        idle(3);
        rb(3'd2, 2'd0, 8'h03);
        wr(12'h46d, 8'h22);
        rb(3'd2, 2'd0, 8'h00);
        rc(12'h46d, 8'h00);
        wr(12'h46d, 8'h02);
        src.burst(0, 2, 1);
        idle(3);
        rb(3'd2, 2'd0, 8'h01);
        wr(12'h46e, 8'h25);
        rb(3'd5, 2'd1, 8'h00);
        wr(12'h46e, 8'h45);
        src.burst(1, 5, 1);
        idle(3);
        rb(3'd5, 2'd1, 8'h00);
    endtask
    task automatic t_irq;
        chk({7'h00, irq}, 8'h00);
        wr(12'h481, 8'h07);
        idle(2);
        chk({7'h00, irq}, 8'h01);
        rc(12'h480, 8'h03);
        src.burst(2, 1, 3);
        idle(3);
        rc(12'h480, 8'h07);
        wr(12'h46d, 8'h82);
        wr(12'h46e, 8'h85);
        wr(12'h46f, 8'h81);
        wr(12'h480, 8'h07);
        idle(2);
        rc(12'h480, 8'h00);
        chk({7'h00, irq}, 8'h00);
    endtask
    task automatic results;
        $display("checks %0d miscompares %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Whole run is well under 2000 cycles; the limit leaves ample margin
    initial begin
        #40000;
        miscompares++;
        results();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        idle(2);
        t_reset();
        t_align();
        t_count();
        t_cmd();
        t_irq();
        results();
    end
endmodule
